// ==== design/mpr_pkg.sv ====
// Purpose: constants for the mode page responder
// Assumes: byte images are built one byte per cycle
// Notes:   page images indexed by byte offset within the page
package mpr_pkg;
  localparam logic [7:0] MPR_PG_GEO   = 8'h1e;
  localparam logic [7:0] MPR_PG_CAP   = 8'h1f;
  localparam logic [7:0] MPR_PG_DSP   = 8'h22;
  localparam logic [7:0] MPR_PG_CFG   = 8'h3d;
  localparam logic [7:0] MPR_PS_BIT   = 8'h80;
  localparam logic [7:0] MPR_LEN_GEO  = 8'h02;
  localparam logic [7:0] MPR_LEN_CAP  = 8'h12;
  localparam logic [7:0] MPR_LEN_DSP  = 8'h52;
  localparam logic [7:0] MPR_LEN_CFG  = 8'h28;
  localparam logic [7:0] MPR_ZERO     = 8'h00;
  // byte offsets inside a page
  localparam logic [6:0] MPR_OFS_CODE = 7'h00;
  localparam logic [6:0] MPR_OFS_LEN  = 7'h01;
  localparam logic [6:0] MPR_OFS_B2   = 7'h02;
  localparam logic [6:0] MPR_OFS_B3   = 7'h03;
  localparam logic [6:0] MPR_OFS_BODY = 7'h04;
  localparam logic [6:0] MPR_OFS_NZ   = 7'h18;
  localparam logic [6:0] MPR_OFS_VZ   = 7'h29;
  localparam logic [6:0] MPR_OFS_HDR  = 7'h02;
  // geometry page: member number always 0, one transport
  localparam logic [7:0] MPR_GEO_TBL [0:3] = '{8'h1e, 8'h02, 8'h00, 8'h00};
  // capabilities: storage bits, move bitmaps, exchange bitmaps
  localparam logic [7:0] MPR_CAP_TBL [0:19] = '{
    8'h1f, 8'h12, 8'h0f, 8'h07,
    8'h0e, 8'h07, 8'h03, 8'h0f,
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h0e, 8'h0f, 8'h0b, 8'h0f,
    8'h00, 8'h00, 8'h00, 8'h00};
  localparam int         MPR_FIFO_W   = 9;
  localparam int         MPR_FIFO_D   = 16;
  typedef enum logic [0:0] {
    MPR_IDLE = 1'b0,
    MPR_GEN  = 1'b1
  } mpr_state_t;
endpackage : mpr_pkg

// ==== design/mpr_fifo.sv ====
// Purpose: byte buffer between page builder and initiator side
// Assumes: one clock, synchronous active-high reset
// Notes:   one extra pointer bit tells full from empty
`timescale 1ns/10ps
module mpr_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
  assign out_valid = (wr_r != rd_r);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= '0;
    end else if (push) begin
      wr_r <= wr_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_r <= '0;
    end else if (pop) begin
      rd_r <= rd_r + 1'b1;
    end
  end
endmodule : mpr_fifo

// ==== design/mpr_top.sv ====
// Purpose: builds mode-sense page bytes for the library controller
// Assumes: display and config stores answer in the same cycle
// Notes:   one byte per cycle into a 16-byte buffer, last flagged
`timescale 1ns/10ps
module mpr_top
  import mpr_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       REQ_VALID,
  input  wire logic [7:0] REQ_PAGE,
  output logic            REQ_READY,
  output logic            PAGE_ERR,
  output logic            BUSY,
  output logic [7:0]      OUT_DATA,
  output logic            OUT_LAST,
  output logic            OUT_VALID,
  input  wire logic       OUT_READY,
  input  wire logic [3:0] LINE_LOADED,
  output logic [6:0]      DISP_IDX,
  input  wire logic [7:0] DISP_CHAR,
  input  wire logic       SEL_VALID,
  input  wire logic [7:0] SEL_INDEX,
  input  wire logic [7:0] CFG_COUNT,
  output logic [7:0]      CFG_IDX,
  output logic [6:0]      CFG_OFS,
  input  wire logic [7:0] CFG_BYTE,
  input  wire logic       CFG_WRITABLE,
  input  wire logic [1:0] CFG_TYPE,
  input  wire logic [4:0] CFG_LEN
);
  mpr_state_t st_r;
  mpr_state_t st_nxt;
  logic [7:0] page_r;
  logic [6:0] idx_r;
  logic [6:0] last_r;
  logic [7:0] cfg_idx_r;
  logic       err_r;
  logic [7:0] byte_nxt;
  logic [7:0] plen;
  logic       known;
  logic       take;
  logic       push;
  logic       push_ready;
  logic       at_last;
  logic [8:0] fifo_out;

  assign REQ_READY = (st_r == MPR_IDLE);
  assign BUSY      = (st_r == MPR_GEN) || OUT_VALID;
  assign take      = REQ_VALID && REQ_READY;
  assign push      = (st_r == MPR_GEN) && push_ready;
  assign at_last   = (idx_r == last_r);
  assign PAGE_ERR  = err_r;
  assign CFG_IDX   = cfg_idx_r;
  // stores are addressed by page byte offset, body-relative for text
  assign DISP_IDX  = idx_r - MPR_OFS_BODY;
  assign CFG_OFS   = idx_r;

  // parameter length decides how many bytes follow the header
  always_comb begin
    known = 1'b1;
    unique case (REQ_PAGE)
      MPR_PG_GEO: plen = MPR_LEN_GEO;
      MPR_PG_CAP: plen = MPR_LEN_CAP;
      MPR_PG_DSP: plen = MPR_LEN_DSP;
      MPR_PG_CFG: plen = MPR_LEN_CFG;
      default: begin
        plen  = MPR_ZERO;
        known = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      MPR_IDLE: begin
        if (take && known) begin
          st_nxt = MPR_GEN;
        end
      end
      MPR_GEN: begin
        if (push && at_last) begin
          st_nxt = MPR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_r <= MPR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // unsupported page: one-cycle flag, no bytes sent
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      err_r <= 1'b0;
    end else begin
      err_r <= take && !known;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      page_r <= MPR_ZERO;
      last_r <= '0;
    end else if (take && known) begin
      page_r <= REQ_PAGE;
      last_r <= plen[6:0] + MPR_OFS_HDR - 7'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      idx_r <= '0;
    end else if (take) begin
      idx_r <= '0;
    end else if (push) begin
      idx_r <= idx_r + 7'h01;
    end
  end

  // a fresh selection beats the step made by a finishing sense,
  // so a select landing in that cycle is never lost
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cfg_idx_r <= MPR_ZERO;
    end else if (SEL_VALID) begin
      cfg_idx_r <= SEL_INDEX;
    end else if (push && at_last && page_r == MPR_PG_CFG) begin
      if (cfg_idx_r + 8'h01 >= CFG_COUNT) begin
        cfg_idx_r <= MPR_ZERO;
      end else begin
        cfg_idx_r <= cfg_idx_r + 8'h01;
      end
    end
  end

  // byte image of the current page at offset idx_r
  always_comb begin
    byte_nxt = MPR_ZERO;
    unique case (page_r)
      MPR_PG_GEO: begin
        byte_nxt = MPR_GEO_TBL[idx_r[1:0]];
      end
      MPR_PG_CAP: begin
        // table holds code 1F with savable bit clear
        if (idx_r <= last_r) begin
          byte_nxt = MPR_CAP_TBL[idx_r[4:0]];
        end
      end
      MPR_PG_DSP: begin
        if (idx_r == MPR_OFS_CODE) begin
          byte_nxt = MPR_PS_BIT | MPR_PG_DSP;
        end else if (idx_r == MPR_OFS_LEN) begin
          byte_nxt = MPR_LEN_DSP;
        end else if (idx_r == MPR_OFS_B2) begin
          // line 1 in bit 3 down to line 4 in bit 0
          byte_nxt = {4'h0, LINE_LOADED};
        end else if (idx_r >= MPR_OFS_BODY) begin
          byte_nxt = DISP_CHAR;
        end
      end
      MPR_PG_CFG: begin
        if (idx_r == MPR_OFS_CODE) begin
          byte_nxt = MPR_PS_BIT | MPR_PG_CFG;
        end else if (idx_r == MPR_OFS_LEN) begin
          byte_nxt = MPR_LEN_CFG;
        end else if (idx_r == MPR_OFS_B2) begin
          byte_nxt = {CFG_WRITABLE, CFG_TYPE, CFG_LEN};
        end else if (idx_r == MPR_OFS_B3 || idx_r == MPR_OFS_NZ
                     || idx_r == MPR_OFS_VZ) begin
          // forced terminators even if the store holds junk
          byte_nxt = MPR_ZERO;
        end else begin
          byte_nxt = CFG_BYTE;
        end
      end
      default: begin
        byte_nxt = MPR_ZERO;
      end
    endcase
  end

  // stalling on a full buffer holds idx_r, so no byte is skipped
  mpr_fifo #(
    .W (MPR_FIFO_W),
    .D (MPR_FIFO_D)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst       (SYS_RST),
    .in_data   ({at_last, byte_nxt}),
    .in_valid  (st_r == MPR_GEN),
    .in_ready  (push_ready),
    .out_data  (fifo_out),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY)
  );

  assign OUT_DATA = fifo_out[7:0];
  assign OUT_LAST = fifo_out[8];
endmodule : mpr_top

// ==== bench/mpr_properties.sv ====
// Purpose: timing and content checks on page bytes
// Assumes: one clock, sync active-high reset
// Notes:   byte position rebuilt from the output handshake
`timescale 1ns/10ps
module mpr_props (
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  input wire logic       REQ_VALID,
  input wire logic [7:0] REQ_PAGE,
  input wire logic       REQ_READY,
  input wire logic       PAGE_ERR,
  input wire logic [7:0] OUT_DATA,
  input wire logic       OUT_LAST,
  input wire logic       OUT_VALID,
  input wire logic       OUT_READY,
  input wire logic [3:0] LINE_LOADED,
  input wire logic       SEL_VALID,
  input wire logic [7:0] SEL_INDEX,
  input wire logic [7:0] CFG_IDX
);
  logic [7:0] pg_r;
  logic [6:0] cnt_r;
  wire        f = OUT_VALID && OUT_READY;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) pg_r <= 8'h00;
    else if (REQ_VALID && REQ_READY) pg_r <= REQ_PAGE;
  end
  // position restarts on the flagged last byte
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || (f && OUT_LAST)) cnt_r <= 7'h00;
    else if (f) cnt_r <= cnt_r + 7'h01;
  end
  property pb(p, c, d);
    f && pg_r == p && cnt_r == c |-> OUT_DATA == d;
  endproperty
  a_geo_len: assert property (pb(8'h1e, 7'h01, 8'h02))
    else $error("geometry length byte wrong");
  a_geo_member: assert property (pb(8'h1e, 7'h03, 8'h00))
    else $error("geometry member byte wrong");
  a_cap_code: assert property (pb(8'h1f, 7'h00, 8'h1f))
    else $error("capability code byte wrong");
  a_cap_len: assert property (pb(8'h1f, 7'h01, 8'h12))
    else $error("capability length byte wrong");
  a_dsp_code: assert property (pb(8'h22, 7'h00, 8'ha2))
    else $error("display code byte wrong");
  a_dsp_len: assert property (pb(8'h22, 7'h01, 8'h52))
    else $error("display length byte wrong");
  a_cfg_code: assert property (pb(8'h3d, 7'h00, 8'hbd))
    else $error("config code byte wrong");
  a_cfg_len: assert property (pb(8'h3d, 7'h01, 8'h28))
    else $error("config length byte wrong");
  // last flag must sit on byte length+1 of whichever page is running
  a_last_pos: assert property (f && OUT_LAST |-> cnt_r ==
      (pg_r == 8'h1e ? 7'h03 : pg_r == 8'h1f ? 7'h13 : pg_r == 8'h22 ? 7'h53 : 7'h29))
    else $error("last flag on wrong byte");
  a_dsp_flags: assert property (pb(8'h22, 7'h02, {4'h0, LINE_LOADED}))
    else $error("display origin flags wrong");
  a_sel_load: assert property (SEL_VALID |=> CFG_IDX == $past(SEL_INDEX))
    else $error("selected item not loaded");
  cover property (f && OUT_LAST && pg_r == 8'h22);
  cover property (f && OUT_LAST && pg_r == 8'h3d);
  cover property (PAGE_ERR);
  cover property (f && OUT_LAST && pg_r == 8'h3d && CFG_IDX == 8'h00);
endmodule : mpr_props
bind mpr_top mpr_props u_props (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .REQ_VALID(REQ_VALID), .REQ_PAGE(REQ_PAGE), .REQ_READY(REQ_READY),
  .PAGE_ERR(PAGE_ERR), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST),
  .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .LINE_LOADED(LINE_LOADED),
  .SEL_VALID(SEL_VALID), .SEL_INDEX(SEL_INDEX), .CFG_IDX(CFG_IDX));

// ==== bench/mpr_sink.sv ====
// Purpose: initiator side that takes page bytes
// Assumes: stall throttles to one byte in eight
// Notes:   keeps the bytes of the current page
`timescale 1ns/10ps
module mpr_sink (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic [7:0] data,
  input  wire logic       valid,
  output logic            ready
);
  logic [7:0] buf_q [0:127];
  logic [2:0] cyc = 3'h0;
  int         n = 0;
  // slow taker lets the builder fill the buffer
  assign ready = !stall || (cyc == 3'h0);
  always @(posedge clk) begin
    cyc <= cyc + 3'h1;
    if (valid && ready) begin
      buf_q[n] <= data;
      n <= n + 1;
    end
  end
endmodule : mpr_sink

// ==== bench/tb_top.sv ====
// Purpose: requests each page and checks its bytes, only the first 16 of the capability page's 20
// Assumes: stores answer in the same cycle
// Notes:   item attributes derived from the item index
`timescale 1ns/10ps
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       rv = 1'b0;
  logic       sv = 1'b0;
  logic       stall = 1'b0;
  logic [7:0] pg = 8'h00;
  logic [7:0] si = 8'h00;
  logic [3:0] ll = 4'ha;
  logic [7:0] x;
  logic       rr, perr, busy, ol, ov, ordy;
  logic [7:0] od, cidx;
  logic [6:0] didx, cofs;
  int         error_cnt = 0;
  int         tests_run = 0;
  logic [7:0] geo_e [0:3] = '{8'h1e, 8'h02, 8'h00, 8'h00};
  logic [7:0] cap_e [0:15] = '{8'h1f, 8'h12, 8'h0f, 8'h07, 8'h0e, 8'h07, 8'h03,
    8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h0f, 8'h0b, 8'h0f};
  mpr_top DUT (.CORE_CLK(clk), .SYS_RST(rst), .REQ_VALID(rv), .REQ_PAGE(pg),
    .REQ_READY(rr), .PAGE_ERR(perr), .BUSY(busy), .OUT_DATA(od), .OUT_LAST(ol),
    .OUT_VALID(ov), .OUT_READY(ordy), .LINE_LOADED(ll), .DISP_IDX(didx),
    .DISP_CHAR({1'b0, didx} + 8'h20), .SEL_VALID(sv), .SEL_INDEX(si),
    .CFG_COUNT(8'h04), .CFG_IDX(cidx), .CFG_OFS(cofs),
    .CFG_BYTE({cidx[3:0], cofs[3:0]}), .CFG_WRITABLE(cidx[0]),
    .CFG_TYPE(cidx[1:0]), .CFG_LEN(cidx[4:0] + 5'h01));
  mpr_sink sk (.clk(clk), .stall(stall), .data(od), .valid(ov), .ready(ordy));
  initial forever #20 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic sense(logic [7:0] p, int nb);
    int k;
    int e;
    @(posedge clk);
    sk.n = 0;
    e = 0;
    rv <= 1'b1;
    pg <= p;
    @(posedge clk);
    rv <= 1'b0;
    for (k = 0; k < 900; k++) begin
      #1;
      e = e + int'(perr === 1'b1);
      if (!busy && k > 3) break;
      @(posedge clk);
    end
    if (k == 900) begin
      error_cnt++;
      stop_test();
    end
    chk("count", 8'(nb), 8'(sk.n));
    chk("perr", 8'(nb == 0), 8'(e));
  endtask : sense
  function automatic logic [7:0] dsp_e(int i);
    case (i)
      0: return 8'ha2;
      1: return 8'h52;
      2: return {4'h0, ll};
      3: return 8'h00;
      default: return 8'(i + 28);
    endcase
  endfunction : dsp_e
  function automatic logic [7:0] cfg_e(int i);
    case (i)
      0: return 8'hbd;
      1: return 8'h28;
      2: return {x[0], x[1:0], x[4:0] + 5'h01};
      3, 24, 41: return 8'h00;
      default: return {x[3:0], 4'(i)};
    endcase
  endfunction : cfg_e
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("ready", 8'h01, 8'(rr));
    chk("valid", 8'h00, 8'(ov));
    chk("cfg_idx", 8'h00, cidx);
    sense(8'h1e, 4);
    sense(8'h1e, 4);
    for (int i = 0; i < 4; i++) chk("geo", geo_e[i], sk.buf_q[i]);
    sense(8'h1f, 20);
    for (int i = 0; i < 16; i++) chk("cap", cap_e[i], sk.buf_q[i]);
    sense(8'h1d, 0);
    stall <= 1'b1;
    sense(8'h22, 84);
    stall <= 1'b0;
    for (int i = 0; i < 84; i++) chk("dsp", dsp_e(i), sk.buf_q[i]);
    @(posedge clk);
    sv <= 1'b1;
    si <= 8'h03;
    @(posedge clk);
    sv <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      x = 8'((v + 3) % 4);
      sense(8'h3d, 42);
      for (int i = 0; i < 42; i++) chk("cfg", cfg_e(i), sk.buf_q[i]);
    end
    stop_test();
  end
endmodule : tb_top
